// ---- core/ara_defines.svh ----
// constants for the converter result accumulator
`ifndef ARA_DEFINES_SVH
`define ARA_DEFINES_SVH
`define ARA_ADDR_RESULT_LOW   8'hBD
`define ARA_ADDR_RESULT_HIGH  8'hBE
`define ARA_ADDR_CONFIG       8'hBC
`define ARA_ADDR_CONTROL      8'hE8
`define ARA_RESULT_RESET      8'h00
`define ARA_CONFIG_RESET      8'hF8
`define ARA_CONTROL_RESET     8'h00
`define ARA_CFG_GAIN_BIT      0
`define ARA_CFG_RPT_LSB       1
`define ARA_CTL_ENABLE_BIT    7
`define ARA_CTL_BURST_BIT     6
`define ARA_CTL_DONE_BIT      5
`define ARA_CTL_BUSY_BIT      4
`define ARA_CTL_WIN_BIT       3
`define ARA_CTL_JUST_BIT      2
`define ARA_CONV_TIME_NS      20
`define ARA_CLK_PERIOD_NS     4
`define ARA_CONV_CYCLES       ((`ARA_CONV_TIME_NS + `ARA_CLK_PERIOD_NS - 1) / `ARA_CLK_PERIOD_NS)
`endif

// ---- core/ara_pkg.sv ----
// types for the converter result accumulator
package ara_pkg;
   typedef enum logic [1:0] {
      ARA_IDLE = 2'b00,
      ARA_CONV = 2'b01,
      ARA_WAIT = 2'b10
   } ara_state_t;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ara_bus_t;
endpackage

// ---- core/ara_conv_timer.sv ----
// self-timed conversion sequencer producing a one-cycle done pulse
`timescale 1ns/100ps
`default_nettype none
`include "ara_defines.svh"
module ara_conv_timer (
   input  wire logic clk_i,
   input  wire logic reset_i,
   input  wire logic start_i,
   output logic      done_o
);
   localparam logic [7:0] CYCLES = 8'(`ARA_CONV_CYCLES);
   logic [7:0] count;
   logic       running;
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         count   <= 8'h00;
         running <= 1'b0;
         done_o  <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (start_i && !running) begin
            running <= 1'b1;
            count   <= CYCLES - 8'h01;
         end else if (running) begin
            if (count == 8'h00) begin
               running <= 1'b0;
               done_o  <= 1'b1;
            end else begin
               count <= count - 8'h01;
            end
         end
      end
   end
endmodule // ara_conv_timer
`default_nettype wire

// ---- core/ara_accumulator.sv ----
// result accumulator with burst sequencing and special-function registers
`timescale 1ns/100ps
`default_nettype none
`include "ara_defines.svh"
////////////////////////////////////////////////////////////////////////////////
module ara_accumulator (
   input  wire logic            clk_i,
   input  wire logic            reset_i,
   input  wire ara_pkg::ara_bus_t bus_i,
   input  wire logic            ext_start_i,
   input  wire logic [11:0]     sample_i,
   input  wire logic            win_lo_i,
   input  wire logic            win_hi_i,
   output logic [7:0]           rdata_o,
   output logic                 conversion_done_event_o,
   output logic                 window_match_event_o,
   output logic                 gain_program_enable_o,
   output logic                 busy_o
);
   ////////////////////////////////////////////////////////////////////////////
   logic [7:0]          result_low_byte;
   logic [7:0]          result_high_byte;
   logic [7:0]          config_reg;
   logic                enable;
   logic                burst;
   logic                done_flag;
   logic                window_match_flag;
   logic                justify_select;
   logic [1:0]          start_mode;
   logic [15:0]         acc;
   logic [4:0]          left;
   logic [4:0]          total;
   logic                timer_start;
   logic                timer_done;
   logic                start;
   logic                ext_meta;
   logic                ext_sync;
   logic                ext_prev;
   logic [15:0]         sum;
   logic                last;
   logic                hit;
   ara_pkg::ara_state_t state;
   logic [1:0]          repeat_count;
   assign repeat_count = config_reg[`ARA_CFG_RPT_LSB +: 2];
   ////////////////////////////////////////////////////////////////////////////
   // start-of-conversion source: software write or synchronised pin edge
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ext_meta <= 1'b0;
         ext_sync <= 1'b0;
         ext_prev <= 1'b0;
      end else begin
         ext_meta <= ext_start_i;
         ext_sync <= ext_meta;
         ext_prev <= ext_sync;
      end
   end
   always_comb begin
      start = 1'b0;
      if (enable) begin
         if (start_mode == 2'b00) begin
            start = bus_i.wr && bus_i.addr == `ARA_ADDR_CONTROL
                    && bus_i.wdata[`ARA_CTL_BUSY_BIT];
         end else begin
            start = ext_sync && !ext_prev;
         end
      end
   end
   always_comb begin
      case (repeat_count)
         2'b00:   total = 5'h01;
         2'b01:   total = 5'h04;
         2'b10:   total = 5'h08;
         default: total = 5'h10;
      endcase
   end
   ////////////////////////////////////////////////////////////////////////////
   // sequencer
   assign sum         = acc + {4'h0, sample_i};
   assign last        = (left == 5'h01);
   assign timer_start = (state == ara_pkg::ARA_IDLE && start)
                        || (state == ara_pkg::ARA_WAIT && start && !burst)
                        || (state == ara_pkg::ARA_CONV && timer_done && burst && !last);
   ara_conv_timer u_timer (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .start_i (timer_start),
      .done_o  (timer_done)
   );
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state <= ara_pkg::ARA_IDLE;
         acc   <= 16'h0000;
         left  <= 5'h00;
      end else begin
         case (state)
            ara_pkg::ARA_IDLE: begin
               if (start) begin
                  acc   <= 16'h0000;
                  left  <= total;
                  state <= ara_pkg::ARA_CONV;
               end
            end
            ara_pkg::ARA_CONV: begin
               if (timer_done) begin
                  acc  <= sum;
                  left <= left - 5'h01;
                  if (last) begin
                     state <= ara_pkg::ARA_IDLE;
                  end else if (!burst) begin
                     state <= ara_pkg::ARA_WAIT;
                  end
               end
            end
            ara_pkg::ARA_WAIT: begin
               if (start) begin
                  state <= ara_pkg::ARA_CONV;
               end
            end
            default: state <= ara_pkg::ARA_IDLE;
         endcase
      end
   end
   assign hit = (state == ara_pkg::ARA_CONV) && timer_done && last;
   ////////////////////////////////////////////////////////////////////////////
   // result pair: loaded only at group end; software may also write it
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         result_low_byte  <= `ARA_RESULT_RESET;
         result_high_byte <= `ARA_RESULT_RESET;
      end else if (hit) begin
         if (justify_select) begin
            result_high_byte <= sum[11:4];
            result_low_byte  <= {sum[3:0], 4'h0};
         end else begin
            result_low_byte <= sum[7:0];
            // four and eight keep the top bits of the sum, so sum bit 8 is not shown
            case (repeat_count)
               2'b00:   result_high_byte <= {4'h0, sum[11:8]};
               2'b01:   result_high_byte <= {3'h0, sum[13:9]};
               2'b10:   result_high_byte <= {2'h0, sum[14:9]};
               default: result_high_byte <= sum[15:8];
            endcase
         end
      end else if (bus_i.wr) begin
         if (bus_i.addr == `ARA_ADDR_RESULT_LOW) begin
            result_low_byte <= bus_i.wdata;
         end
         if (bus_i.addr == `ARA_ADDR_RESULT_HIGH) begin
            result_high_byte <= bus_i.wdata;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // configuration and control; hardware set wins over a software clear
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         config_reg <= `ARA_CONFIG_RESET;
      end else if (bus_i.wr && bus_i.addr == `ARA_ADDR_CONFIG) begin
         config_reg <= bus_i.wdata;
      end
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         enable            <= 1'b0;
         burst             <= 1'b0;
         justify_select    <= 1'b0;
         start_mode        <= 2'b00;
         done_flag         <= 1'b0;
         window_match_flag <= 1'b0;
      end else begin
         if (bus_i.wr && bus_i.addr == `ARA_ADDR_CONTROL) begin
            enable         <= bus_i.wdata[`ARA_CTL_ENABLE_BIT];
            burst          <= bus_i.wdata[`ARA_CTL_BURST_BIT];
            justify_select <= bus_i.wdata[`ARA_CTL_JUST_BIT];
            start_mode     <= bus_i.wdata[1:0];
            done_flag      <= bus_i.wdata[`ARA_CTL_DONE_BIT];
            window_match_flag <= bus_i.wdata[`ARA_CTL_WIN_BIT];
         end
         if (hit) begin
            done_flag <= 1'b1;
            if (win_hi_i || win_lo_i) begin
               window_match_flag <= 1'b1;
            end
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // registered outputs and read data
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rdata_o                 <= 8'h00;
         conversion_done_event_o <= 1'b0;
         window_match_event_o    <= 1'b0;
         gain_program_enable_o   <= 1'b0;
         busy_o                  <= 1'b0;
      end else begin
         conversion_done_event_o <= hit;
         window_match_event_o    <= hit && (win_hi_i || win_lo_i);
         gain_program_enable_o   <= config_reg[`ARA_CFG_GAIN_BIT];
         busy_o                  <= (state != ara_pkg::ARA_IDLE);
         if (bus_i.rd) begin
            case (bus_i.addr)
               `ARA_ADDR_RESULT_LOW:  rdata_o <= result_low_byte;
               `ARA_ADDR_RESULT_HIGH: rdata_o <= result_high_byte;
               `ARA_ADDR_CONFIG:      rdata_o <= config_reg;
               `ARA_ADDR_CONTROL:     rdata_o <= {enable, burst, done_flag,
                                          state == ara_pkg::ARA_CONV, window_match_flag,
                                          justify_select, start_mode};
               default:               rdata_o <= 8'h00;
            endcase
         end
      end
   end
endmodule // ara_accumulator
`default_nettype wire

// ---- sim/ara_accumulator_checker.sv ----
// concurrent checks on the accumulator ports
`timescale 1ns/100ps
`default_nettype none
`include "ara_defines.svh"
module ara_accumulator_checker (
   input wire logic              clk_i,
   input wire logic              reset_i,
   input wire ara_pkg::ara_bus_t bus_i,
   input wire logic              ext_start_i,
   input wire logic [11:0]       sample_i,
   input wire logic              win_lo_i,
   input wire logic              win_hi_i,
   input wire logic [7:0]        rdata_o,
   input wire logic              conversion_done_event_o,
   input wire logic              window_match_event_o,
   input wire logic              gain_program_enable_o,
   input wire logic              busy_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   logic st;
   // register start; a pin start reaches busy four cycles after the pin is sampled
   assign st = bus_i.wr && bus_i.addr == `ARA_ADDR_CONTROL && bus_i.wdata[4];
   a_done_one_pulse: assert property (conversion_done_event_o |=> !conversion_done_event_o)
      else $error("done event longer than one cycle");
   a_win_with_done: assert property (window_match_event_o |-> conversion_done_event_o)
      else $error("window event without done event");
   a_win_cause: assert property (conversion_done_event_o |->
      window_match_event_o == $past(win_lo_i || win_hi_i))
      else $error("window event does not follow compare inputs");
   a_busy_after_done: assert property (conversion_done_event_o |=> !busy_o)
      else $error("busy still high after group end");
   a_conv_min_time: assert property (conversion_done_event_o |-> $past(busy_o, 5))
      else $error("group ended sooner than one conversion");
   a_busy_start_cause: assert property ($rose(busy_o) |->
      $past(st) || $past(st, 2) || $past(ext_start_i, 4))
      else $error("busy rose without a start");
   a_gain_bit_copy: assert property (bus_i.wr && bus_i.addr == `ARA_ADDR_CONFIG |->
      ##2 gain_program_enable_o == $past(bus_i.wdata[0], 2))
      else $error("gain enable does not follow config bit");
   a_rdata_hold: assert property (!$past(bus_i.rd) |-> $stable(rdata_o))
      else $error("read data changed without a read");
endmodule // ara_accumulator_checker
bind ara_accumulator ara_accumulator_checker chk_i (.*);
`default_nettype wire

// ---- sim/ara_accumulator_bench.sv ----
// self-checking bench for the accumulator
`timescale 1ns/100ps
`default_nettype none
`include "ara_defines.svh"
module ara_accumulator_bench;
   logic              clk_i = 0, reset_i = 1, win_lo_i = 0, win_hi_i = 0, ext_start_i = 0;
   ara_pkg::ara_bus_t bus_i = '0;
   logic [11:0]       sample_i = '0;
   logic [7:0]        rdata_o;
   logic              done_o, win_o, gain_o, busy_o;
   int                mismatches = 0, comparisons = 0, dones, wins;
   ara_accumulator dut (.clk_i(clk_i), .reset_i(reset_i), .bus_i(bus_i),
      .ext_start_i(ext_start_i), .sample_i(sample_i), .win_lo_i(win_lo_i), .win_hi_i(win_hi_i),
      .rdata_o(rdata_o), .conversion_done_event_o(done_o), .window_match_event_o(win_o),
      .gain_program_enable_o(gain_o), .busy_o(busy_o));
   initial begin
      forever #2 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      if (done_o === 1'b1) dones++;
      if (win_o === 1'b1) wins++;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i) bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_i) bus_i <= '0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i) bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_i) bus_i <= '0;
      @(posedge clk_i) d = rdata_o;
   endtask
   // pair layout per repeat count; four and eight drop sum bit 8 from the pair
   function automatic logic [15:0] fmt(input logic [15:0] s, input logic [1:0] rpt,
                                       input logic lj);
      if (lj) return {s[11:0], 4'h0};
      case (rpt)
         2'b00:   return {4'h0, s[11:0]};
         2'b01:   return {3'h0, s[13:9], s[7:0]};
         2'b10:   return {2'h0, s[14:9], s[7:0]};
         default: return s;
      endcase
   endfunction
   task automatic group(input logic [1:0] rpt, input logic bst, input logic lj, input logic top);
      logic [7:0]  ctl, hi, lo, g;
      logic [15:0] sum;
      logic [11:0] s;
      logic [1:0]  w;
      int          n;
      n = (rpt == 2'b00) ? 1 : (2 << rpt);
      g = 8'($urandom_range(1));
      w = 2'($urandom);
      wr(`ARA_ADDR_CONFIG, {5'h1F, rpt, g[0]});
      repeat (2) @(posedge clk_i);
      chk(gain_o, g);
      ctl = {1'b1, bst, 3'b000, lj, 1'b0, top};
      wr(`ARA_ADDR_CONTROL, ctl);
      win_lo_i <= w[0];
      win_hi_i <= w[1];
      dones = 0;
      wins = 0;
      sum = '0;
      for (int i = 0; i < (bst ? 1 : n); i++) begin
         s = top ? 12'hFFF : 12'($urandom);
         sample_i <= s;
         chk(16'(dones), 16'h0000);
         if (top) begin
            ext_start_i <= 1'b1;
            @(posedge clk_i) ext_start_i <= 1'b0;
         end else begin
            wr(`ARA_ADDR_CONTROL, ctl | 8'h10);
         end
         sum += bst ? 16'(n * s) : 16'(s);
         repeat (4) @(posedge clk_i);
         chk(16'(busy_o), 16'h0001);
         repeat (6) @(posedge clk_i);
      end
      for (int k = 0; k < 300 && dones == 0; k++) @(posedge clk_i);
      chk(16'(dones), 16'h0001);
      chk(16'(wins), 16'(|w));
      rd(`ARA_ADDR_RESULT_HIGH, hi);
      rd(`ARA_ADDR_RESULT_LOW, lo);
      chk({hi, lo}, fmt(sum, rpt, lj));
      rd(`ARA_ADDR_CONTROL, hi);
      chk(hi & 8'h28, {2'b00, 1'b1, 1'b0, |w, 3'b000});
      chk(16'(busy_o), 16'h0000);
   endtask
   task automatic report_and_stop;
      if (mismatches == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] d;
      void'($urandom(21551));
      repeat (3) @(posedge clk_i);
      reset_i <= 1'b0;
      rd(`ARA_ADDR_RESULT_LOW, d);
      chk(d, `ARA_RESULT_RESET);
      rd(`ARA_ADDR_RESULT_HIGH, d);
      chk(d, `ARA_RESULT_RESET);
      rd(`ARA_ADDR_CONFIG, d);
      chk(d, `ARA_CONFIG_RESET);
      rd(`ARA_ADDR_CONTROL, d);
      chk(d, `ARA_CONTROL_RESET);
      // second pass: full-scale samples fill every sum width, starts come from the pin
      for (int t = 0; t < 2; t++)
         for (int r = 0; r < 4; r++)
            for (int m = 0; m < ((r == 0) ? 4 : 2); m++)
               group(2'(r), m[0], m[1], t[0]);
      report_and_stop();
   end
   initial begin
      #200000;
      mismatches++;
      report_and_stop();
   end
endmodule // ara_accumulator_bench
`default_nettype wire
